/* File: rtl/hsbi_cfg.svh */
`ifndef HSBI_CFG_SVH
`define HSBI_CFG_SVH
`define HSBI_RS_W 4
`define HSBI_DMA_CYC_LEN 4'h4
`define HSBI_DMA_T2 4'h1
`define HSBI_VEC_RST 8'h00
`endif

/* File: rtl/hsbi_pkg.sv */
package hsbi_pkg;
   typedef enum logic [2:0] {
      HSBI_IDLE = 3'b000,
      HSBI_REQ = 3'b001,
      HSBI_OWN = 3'b010,
      HSBI_CYC = 3'b011,
      HSBI_DROP = 3'b100
   } hsbi_arb_t;
   typedef struct packed {
      logic cs_n;
      logic [3:0] rs;
      logic bhe_n;
   } hsbi_sel_t;
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } hsbi_word_t;
endpackage

/* File: rtl/hsbi_sel_latch.sv */
`timescale 1ns/1ps
`include "hsbi_cfg.svh"
// Select latch on the bus clock; strobe and selects are already synchronised
module hsbi_sel_latch (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Strobe and live selects
   input wire logic strobe,
   input wire hsbi_pkg::hsbi_sel_t sel_in,
   // Latched view
   output hsbi_pkg::hsbi_sel_t sel_out
);
   hsbi_pkg::hsbi_sel_t held_r, held_nxt;
   always_comb begin
      held_nxt = held_r;
      if (strobe) begin
         held_nxt = sel_in;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         held_r <= '{cs_n: 1'b1, rs: 4'h0, bhe_n: 1'b1};
      end else begin
         held_r <= held_nxt;
      end
   end
   // Transparent while high, frozen value of the last high cycle while low
   assign sel_out = strobe ? sel_in : held_r;
endmodule

/* File: rtl/hsbi_top.sv */
`timescale 1ns/1ps
`include "hsbi_cfg.svh"
module hsbi_top (
   // Core clock and reset
   input wire logic clk,
   input wire logic nrst,
   // System bus clock domain
   input wire logic system_bus_clock,
   // Configuration
   input wire logic bus_style_sel,
   input wire logic bus_width_select,
   input wire logic parity_en,
   // Core side requests
   input wire logic dma_start,
   input wire logic dma_write,
   input wire hsbi_pkg::hsbi_word_t dma_wdata,
   input wire logic int_pending,
   input wire logic [7:0] int_vector,
   input wire hsbi_pkg::hsbi_word_t reg_rdata,
   // Core side status
   output logic dma_busy,
   output logic dma_done,
   output hsbi_pkg::hsbi_word_t dma_rdata,
   output logic parity_err,
   output hsbi_pkg::hsbi_sel_t sel_latched,
   output logic first_style,
   output logic narrow_bus,
   // Bus control pins
   output logic buffer_direction_out,
   output logic hold_request_out,
   input wire logic hold_acknowledge_in,
   input wire logic bus_release_in,
   output logic bus_owned_out,
   output logic interrupt_request_out,
   input wire logic interrupt_acknowledge_in,
   input wire logic select_latch_strobe,
   input wire logic chip_select_n,
   input wire logic [3:0] register_select,
   input wire logic byte_high_enable_n,
   // Read strobe, two-way
   input wire logic read_strobe_n_i,
   output logic read_strobe_n_o,
   output logic read_strobe_n_oe,
   // Address/data lanes, two-way
   input wire hsbi_pkg::hsbi_word_t addr_data_i,
   output hsbi_pkg::hsbi_word_t addr_data_o,
   output logic addr_data_oe,
   input wire logic parity_high_lane_i,
   input wire logic parity_low_lane_i,
   output logic parity_high_lane_o,
   output logic parity_low_lane_o,
   output logic parity_oe
);
   // Odd parity bit for a byte
   function automatic logic odd_par(input logic [7:0] b);
      odd_par = ~(^b);
   endfunction

   // Reset release in each domain
   logic [1:0] rst_c_r;
   logic [1:0] rst_b_r;
   logic rst_n;
   logic brst_n;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_c_r <= 2'h0;
      end else begin
         rst_c_r <= {rst_c_r[0], 1'b1};
      end
   end
   always_ff @(posedge system_bus_clock or negedge nrst) begin
      if (!nrst) begin
         rst_b_r <= 2'h0;
      end else begin
         rst_b_r <= {rst_b_r[0], 1'b1};
      end
   end
   assign rst_n = rst_c_r[1];
   assign brst_n = rst_b_r[1];

   // Pin synchronisers in the bus clock domain
   localparam int NS = 10;
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] s1_r;
   logic [NS-1:0] s2_r;
   assign pin_raw = {hold_acknowledge_in, bus_release_in,
                     interrupt_acknowledge_in, select_latch_strobe,
                     chip_select_n, register_select, byte_high_enable_n};
   always_ff @(posedge system_bus_clock or negedge brst_n) begin
      if (!brst_n) begin
         s1_r <= 10'h3ff;
         s2_r <= 10'h3ff;
      end else begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
      end
   end
   logic hlda_s, rls_n_s, iack_n_s, strobe_s;
   hsbi_pkg::hsbi_sel_t sel_s;
   assign hlda_s = s2_r[9];
   assign rls_n_s = s2_r[8];
   assign iack_n_s = s2_r[7];
   assign strobe_s = s2_r[6];
   assign sel_s = s2_r[5:0];

   hsbi_sel_latch u_sel (
      .clk(system_bus_clock),
      .rst_n(brst_n),
      .strobe(strobe_s),
      .sel_in(sel_s),
      .sel_out(sel_latched)
   );

   // Style and width configuration, synchronised to the bus clock
   logic [1:0] sty_r, wid_r;
   always_ff @(posedge system_bus_clock or negedge brst_n) begin
      if (!brst_n) begin
         sty_r <= 2'h3;
         wid_r <= 2'h3;
      end else begin
         sty_r <= {sty_r[0], bus_style_sel};
         wid_r <= {wid_r[0], bus_width_select};
      end
   end
   assign first_style = sty_r[1];
   assign narrow_bus = wid_r[1];

   // Direct access is only seen by the first style's decode
   logic dio_sel, dio_rd, host_rd_n;
   logic [1:0] rd_s_r;
   // Host read strobe is a pin, so it passes two stages like the others
   always_ff @(posedge system_bus_clock or negedge brst_n) begin
      if (!brst_n) begin
         rd_s_r <= 2'h3;
      end else begin
         rd_s_r <= {rd_s_r[0], read_strobe_n_i};
      end
   end
   assign host_rd_n = rd_s_r[1];
   assign dio_sel = first_style && !sel_latched.cs_n;

   // Core-domain DMA start crosses by toggle
   logic start_tg_r, start_tg_nxt;
   logic [2:0] start_s_r;
   logic start_pend_r, start_pend_nxt;
   logic done_tg_r, done_tg_nxt;
   logic [2:0] done_s_r;
   always_comb begin
      start_tg_nxt = start_tg_r ^ (dma_start && !dma_busy);
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_tg_r <= 1'b0;
         done_s_r <= 3'h0;
      end else begin
         start_tg_r <= start_tg_nxt;
         done_s_r <= {done_s_r[1:0], done_tg_r};
      end
   end
   assign dma_done = done_s_r[2] ^ done_s_r[1];

   // Core-domain busy flag
   logic busy_r, busy_nxt;
   always_comb begin
      busy_nxt = busy_r;
      if (dma_start && !busy_r) begin
         busy_nxt = 1'b1;
      end else if (dma_done) begin
         busy_nxt = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
      end
   end
   assign dma_busy = busy_r;

   // Bus arbitration and DMA cycle in the bus clock domain
   hsbi_pkg::hsbi_arb_t st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic hrq_r, hrq_nxt, own_r, own_nxt;
   logic wr_r, wr_nxt;
   hsbi_pkg::hsbi_word_t rdat_r, rdat_nxt;
   logic perr_r, perr_nxt;
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      hrq_nxt = hrq_r;
      own_nxt = own_r;
      wr_nxt = wr_r;
      rdat_nxt = rdat_r;
      perr_nxt = perr_r;
      start_pend_nxt = start_pend_r;
      done_tg_nxt = done_tg_r;
      unique case (st_r)
         hsbi_pkg::HSBI_IDLE: begin
            if (start_pend_r && first_style) begin
               hrq_nxt = 1'b1;
               st_nxt = hsbi_pkg::HSBI_REQ;
            end
         end
         hsbi_pkg::HSBI_REQ: begin
            if (hlda_s) begin
               own_nxt = 1'b1;
               st_nxt = hsbi_pkg::HSBI_OWN;
            end
         end
         hsbi_pkg::HSBI_OWN: begin
            wr_nxt = dma_write;
            cnt_nxt = 4'h0;
            st_nxt = hsbi_pkg::HSBI_CYC;
         end
         hsbi_pkg::HSBI_CYC: begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == `HSBI_DMA_T2 && !wr_r) begin
               rdat_nxt = addr_data_i;
               perr_nxt = parity_en &&
                  ((odd_par(addr_data_i.hi) != parity_high_lane_i) ||
                   (odd_par(addr_data_i.lo) != parity_low_lane_i));
            end
            if (cnt_r == `HSBI_DMA_CYC_LEN - 4'h1) begin
               // Four-cycle transfer ends; release gives same outcome
               start_pend_nxt = !rls_n_s && start_pend_r &&
                  !(start_s_r[2] ^ start_s_r[1]) ? 1'b0 : 1'b0;
               done_tg_nxt = ~done_tg_r;
               st_nxt = hsbi_pkg::HSBI_DROP;
            end
         end
         hsbi_pkg::HSBI_DROP: begin
            hrq_nxt = 1'b0;
            own_nxt = 1'b0;
            st_nxt = hsbi_pkg::HSBI_IDLE;
         end
         default: begin
            st_nxt = hsbi_pkg::HSBI_IDLE;
            hrq_nxt = 1'b0;
            own_nxt = 1'b0;
         end
      endcase
      // A start arriving as the old one retires must not be lost
      if (start_s_r[2] ^ start_s_r[1]) begin
         start_pend_nxt = 1'b1;
      end
   end
   always_ff @(posedge system_bus_clock or negedge brst_n) begin
      if (!brst_n) begin
         st_r <= hsbi_pkg::HSBI_IDLE;
         cnt_r <= 4'h0;
         hrq_r <= 1'b0;
         own_r <= 1'b0;
         wr_r <= 1'b0;
         rdat_r <= 16'h0000;
         perr_r <= 1'b0;
         start_pend_r <= 1'b0;
         done_tg_r <= 1'b0;
         start_s_r <= 3'h0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         hrq_r <= hrq_nxt;
         own_r <= own_nxt;
         wr_r <= wr_nxt;
         rdat_r <= rdat_nxt;
         perr_r <= perr_nxt;
         start_pend_r <= start_pend_nxt;
         done_tg_r <= done_tg_nxt;
         start_s_r <= {start_s_r[1:0], start_tg_r};
      end
   end
   // Read data is stable once done crosses, so taken without resync
   assign dma_rdata = rdat_r;
   assign parity_err = perr_r;

   logic in_cyc;
   assign in_cyc = (st_r == hsbi_pkg::HSBI_CYC);
   assign hold_request_out = hrq_r;
   assign bus_owned_out = ~own_r;

   // Interrupt request and vector, bus clock domain
   logic [1:0] ip_r;
   always_ff @(posedge system_bus_clock or negedge brst_n) begin
      if (!brst_n) begin
         ip_r <= 2'h0;
      end else begin
         ip_r <= {ip_r[0], int_pending};
      end
   end
   assign interrupt_request_out = ip_r[1];
   logic vec_out;
   assign vec_out = !iack_n_s && ip_r[1];

   // Direction and data drive
   assign dio_rd = dio_sel && !host_rd_n && !own_r;
   always_comb begin
      buffer_direction_out = 1'b1;
      if (in_cyc) begin
         buffer_direction_out = wr_r;
      end else if (dio_sel && !own_r) begin
         buffer_direction_out = !host_rd_n || vec_out;
      end
   end
   // Device drives the read strobe whenever it owns the bus, low only in a DMA read
   assign read_strobe_n_oe = own_r;
   assign read_strobe_n_o = !(in_cyc && !wr_r);

   hsbi_pkg::hsbi_word_t drv;
   always_comb begin
      drv = reg_rdata;
      if (vec_out) begin
         drv = {`HSBI_VEC_RST, int_vector};
      end else if (in_cyc) begin
         drv = dma_wdata;
      end
      if (narrow_bus && !in_cyc) begin
         drv.hi = `HSBI_VEC_RST;
      end
   end
   assign addr_data_o = drv;
   assign addr_data_oe = dio_rd || vec_out || (in_cyc && wr_r);
   assign parity_high_lane_o = odd_par(drv.hi);
   assign parity_low_lane_o = odd_par(drv.lo);
   assign parity_oe = addr_data_oe && parity_en;
endmodule

/* File: sim/hsbi_props.sv */
`timescale 1ns/1ps
module hsbi_props (
   // Clocks and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic system_bus_clock,
   // Watched ports
   input wire logic int_pending,
   input wire logic interrupt_request_out,
   input wire logic interrupt_acknowledge_in,
   input wire logic chip_select_n,
   input wire logic select_latch_strobe,
   input wire hsbi_pkg::hsbi_sel_t sel_latched,
   input wire logic bus_owned_out,
   input wire logic hold_request_out,
   input wire logic hold_acknowledge_in,
   input wire logic buffer_direction_out,
   input wire logic read_strobe_n_o,
   input wire logic read_strobe_n_oe,
   input wire hsbi_pkg::hsbi_word_t addr_data_o,
   input wire logic addr_data_oe,
   input wire logic parity_high_lane_o,
   input wire logic parity_low_lane_o,
   input wire logic parity_oe
);
   // Pins pass two sync stages, hence the run-in repetitions
   default clocking @(posedge system_bus_clock); endclocking
   default disable iff (!nrst);

   idle_dir_a: assert property (
      (sel_latched.cs_n && interrupt_acknowledge_in && bus_owned_out)[*5]
      |-> buffer_direction_out) else $error("direction not idle high");
   dma_rd_dir_a: assert property (
      (!bus_owned_out && read_strobe_n_oe && !read_strobe_n_o)[*2]
      |-> !buffer_direction_out) else $error("dma read not inward");
   own_grant_a: assert property (
      $fell(bus_owned_out) |-> hold_request_out
      && $past(hold_acknowledge_in, 2)) else $error("owned before grant");
   own_req_a: assert property (
      !bus_owned_out |-> hold_request_out) else $error("owned sans request");
   rd_drive_a: assert property (
      read_strobe_n_oe |-> !bus_owned_out) else $error("strobe not owned");
   parity_a: assert property (
      parity_oe && addr_data_oe |-> ^{addr_data_o.hi, parity_high_lane_o}
      && ^{addr_data_o.lo, parity_low_lane_o}) else $error("parity even");
   latch_hold_a: assert property (
      (!select_latch_strobe)[*5] |-> $stable(sel_latched))
      else $error("latch moved");
   irq_rise_a: assert property (
      $rose(int_pending) |-> ##[1:16] interrupt_request_out)
      else $error("no interrupt request");
   vec_drive_a: assert property (
      (!interrupt_acknowledge_in && interrupt_request_out)[*5]
      |-> addr_data_oe
      && buffer_direction_out) else $error("vector not driven");
endmodule

bind hsbi_top hsbi_props u_props (.clk, .nrst, .system_bus_clock,
   .int_pending, .interrupt_request_out, .interrupt_acknowledge_in,
   .chip_select_n, .select_latch_strobe, .sel_latched, .bus_owned_out,
   .hold_request_out, .hold_acknowledge_in, .buffer_direction_out,
   .read_strobe_n_o, .read_strobe_n_oe, .addr_data_o, .addr_data_oe,
   .parity_high_lane_o, .parity_low_lane_o, .parity_oe);

/* File: sim/hsbi_host_model.sv */
`timescale 1ns/1ps
module hsbi_host_model (
   // Bus clock
   input wire logic system_bus_clock,
   // Arbiter
   input wire logic hold_request_out,
   input wire logic [3:0] gnt_dly,
   output logic hold_acknowledge_in,
   // Lanes
   input wire logic bus_owned_out,
   input wire logic read_strobe_n_i,
   input wire logic addr_data_oe,
   input wire hsbi_pkg::hsbi_word_t addr_data_o,
   input wire hsbi_pkg::hsbi_word_t mem,
   output hsbi_pkg::hsbi_word_t addr_data_i,
   output hsbi_pkg::hsbi_word_t seen
);
   logic [3:0] wait_r = 4'h0;
   logic host_drv;
   initial hold_acknowledge_in = 1'b0;
   // Grant after a chosen wait, withdrawn at once with the request
   always @(posedge system_bus_clock) begin
      if (!hold_request_out)
         wait_r <= 4'h0;
      else if (wait_r != 4'hf)
         wait_r <= wait_r + 4'h1;
      hold_acknowledge_in <= hold_request_out && wait_r >= gnt_dly;
      if (addr_data_oe && !bus_owned_out)
         seen <= addr_data_o;
   end
   // Host feeds DMA reads; released lanes rise to their pull-ups
   assign host_drv = !bus_owned_out && !read_strobe_n_i && !addr_data_oe;
   assign addr_data_i = addr_data_oe ? addr_data_o :
      host_drv ? mem : 16'hffff;
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, nrst = 1'b0, system_bus_clock = 1'b0;
   logic bus_style_sel = 1'b1, bus_width_select = 1'b0, parity_en = 1'b1;
   logic dma_start = 1'b0, dma_write = 1'b0, int_pending = 1'b0;
   logic bus_release_in = 1'b1, interrupt_acknowledge_in = 1'b1;
   logic select_latch_strobe = 1'b1, chip_select_n = 1'b1;
   logic byte_high_enable_n = 1'b1, host_rd_n = 1'b1;
   logic [3:0] register_select = 4'h0, gnt_dly = 4'h0;
   logic [7:0] int_vector = 8'h00;
   hsbi_pkg::hsbi_word_t dma_wdata = 16'h0000, reg_rdata = 16'h0000;
   hsbi_pkg::hsbi_word_t mem = 16'h0000, addr_data_i, addr_data_o;
   hsbi_pkg::hsbi_word_t dma_rdata, seen;
   hsbi_pkg::hsbi_sel_t sel_latched;
   logic dma_busy, dma_done, parity_err, first_style, narrow_bus;
   logic buffer_direction_out, hold_request_out, hold_acknowledge_in;
   logic bus_owned_out, interrupt_request_out, read_strobe_n_i;
   logic read_strobe_n_o, read_strobe_n_oe, addr_data_oe, parity_oe;
   logic parity_high_lane_i, parity_low_lane_i;
   logic parity_high_lane_o, parity_low_lane_o;
   int mismatches = 0, checked = 0, cycles = 0;

   initial forever #20 clk = ~clk;
   initial begin
      #1.3;
      forever #3 system_bus_clock = ~system_bus_clock;
   end

   assign read_strobe_n_i = read_strobe_n_oe ? read_strobe_n_o : host_rd_n;
   assign parity_high_lane_i = parity_oe ? parity_high_lane_o :
      ~^addr_data_i.hi;
   assign parity_low_lane_i = parity_oe ? parity_low_lane_o :
      ~^addr_data_i.lo;

   hsbi_top dut (.clk, .nrst, .system_bus_clock, .bus_style_sel,
      .bus_width_select, .parity_en, .dma_start, .dma_write, .dma_wdata,
      .int_pending, .int_vector, .reg_rdata, .dma_busy, .dma_done,
      .dma_rdata, .parity_err, .sel_latched, .first_style, .narrow_bus,
      .buffer_direction_out, .hold_request_out, .hold_acknowledge_in,
      .bus_release_in, .bus_owned_out, .interrupt_request_out,
      .interrupt_acknowledge_in, .select_latch_strobe, .chip_select_n,
      .register_select, .byte_high_enable_n, .read_strobe_n_i,
      .read_strobe_n_o, .read_strobe_n_oe, .addr_data_i, .addr_data_o,
      .addr_data_oe, .parity_high_lane_i, .parity_low_lane_i,
      .parity_high_lane_o, .parity_low_lane_o, .parity_oe);
   hsbi_host_model host (.system_bus_clock, .hold_request_out, .gnt_dly,
      .hold_acknowledge_in, .bus_owned_out, .read_strobe_n_i, .addr_data_oe,
      .addr_data_o, .mem, .addr_data_i, .seen);

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic dma(input logic w, input logic [15:0] d);
      int n;
      // A start while busy is refused, so wait for the last one to retire
      for (n = 0; n < 300 && dma_busy !== 1'b0; n++)
         tick(1);
      dma_write = w;
      dma_wdata = d;
      dma_start = 1'b1;
      tick(1);
      dma_start = 1'b0;
      chk("busy", 16'h0001, dma_busy);
      for (n = 0; n < 300 && dma_done !== 1'b1; n++)
         tick(1);
      chk("done", 16'h0001, dma_done);
   endtask
   task automatic wrap_up();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Whole run needs well under 2000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         wrap_up();
      end
   end

   initial begin
      tick(16);
      nrst = 1'b1;
      tick(4);
      chk("hold_req", 16'h0000, hold_request_out);
      chk("owned", 16'h0001, bus_owned_out);
      chk("dir", 16'h0001, buffer_direction_out);
      chk("style", 16'h0001, first_style);
      // Prompt grant, then a slow one with release low meanwhile
      for (int i = 0; i < 2; i++) begin
         gnt_dly = i ? 4'h9 : 4'h0;
         bus_release_in = !i;
         mem = i ? 16'ha5f0 : 16'h5a3c;
         dma(1'b0, 16'h0000);
         chk("rd", mem, dma_rdata);
         chk("perr", 16'h0000, parity_err);
         chk("own_end", 16'h0001, bus_owned_out);
      end
      bus_release_in = 1'b1;
      dma(1'b1, 16'hc3e1);
      chk("wr", 16'hc3e1, seen);
      reg_rdata = 16'hb6e9;
      for (int w = 0; w < 2; w++) begin
         bus_width_select = w[0];
         chip_select_n = 1'b0;
         host_rd_n = 1'b0;
         tick(2);
         chk("dio", w ? 16'h00e9 : 16'hb6e9, addr_data_o);
         chk("dio_dir", 16'h0001, buffer_direction_out);
         chk("dio_oe", 16'h0001, addr_data_oe);
         chip_select_n = 1'b1;
         host_rd_n = 1'b1;
         tick(2);
      end
      chk("narrow", 16'h0001, narrow_bus);
      bus_width_select = 1'b0;
      int_vector = 8'h7e;
      int_pending = 1'b1;
      tick(2);
      chk("irq", 16'h0001, interrupt_request_out);
      interrupt_acknowledge_in = 1'b0;
      tick(2);
      chk("vec", 16'h007e, {8'h00, addr_data_o.lo});
      chk("vec_oe", 16'h0001, addr_data_oe);
      interrupt_acknowledge_in = 1'b1;
      int_pending = 1'b0;
      tick(2);
      chk("irq_off", 16'h0000, interrupt_request_out);
      chip_select_n = 1'b0;
      register_select = 4'ha;
      byte_high_enable_n = 1'b0;
      tick(2);
      chk("sel_open", 16'h0014, sel_latched);
      select_latch_strobe = 1'b0;
      tick(2);
      chip_select_n = 1'b1;
      register_select = 4'h5;
      byte_high_enable_n = 1'b1;
      tick(2);
      chk("sel_held", 16'h0014, sel_latched);
      select_latch_strobe = 1'b1;
      tick(2);
      chk("sel_back", 16'h002b, sel_latched);
      bus_style_sel = 1'b0;
      tick(2);
      chk("style2", 16'h0000, first_style);
      dma_start = 1'b1;
      tick(1);
      dma_start = 1'b0;
      tick(10);
      chk("no_req", 16'h0000, hold_request_out);
      wrap_up();
   end
endmodule
